// *** design/sfwl_regs.svh ***
/*
 * constants of the serial flash write loader: protocol bytes, error codes,
 * blank-region bounds and the default baud divisor.
 * assumes inclusion by design/sfwl_pkg.sv and the loader module.
 */
`ifndef SFWL_REGS_SVH
`define SFWL_REGS_SVH

// ----------------------------------------------------------------
// protocol bytes
// ----------------------------------------------------------------
`define SFWL_MATCH_BYTE     8'h5A
`define SFWL_RATE_DEFAULT   8'h28
`define SFWL_CMD_WRITE      8'h30
`define SFWL_START_MARK     8'h3A
`define SFWL_ERR_A1         8'hA1
`define SFWL_ERR_A3         8'hA3
`define SFWL_ERR_RATE       8'h62
`define SFWL_ERR_CMD        8'h63
`define SFWL_ERR_REPEAT     2'h3
`define SFWL_REC_DATA       8'h00
`define SFWL_REC_END        8'h01

// ----------------------------------------------------------------
// blank region and timing
// ----------------------------------------------------------------
`define SFWL_BLANK_FIRST    16'hFFE0
`define SFWL_BLANK_LAST     16'hFFFF
`define SFWL_ERASED         8'hFF
`define SFWL_CLK_HZ         100000000
`define SFWL_BAUD_INIT      9600
`define SFWL_DIV_INIT       (`SFWL_CLK_HZ / `SFWL_BAUD_INIT)

`endif

// *** design/sfwl_pkg.sv ***
/*
 * types of the serial flash write loader.
 * assumes the constants header sits beside it.
 */
`include "sfwl_regs.svh"
package sfwl_pkg;
    // ----------------------------------------------------------------
    // loader states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        SFWL_MATCH, SFWL_ECHO_MATCH, SFWL_RATE, SFWL_ECHO_RATE, SFWL_CMD, SFWL_ECHO_CMD,
        SFWL_ADDR, SFWL_BLANK, SFWL_CNT_RD, SFWL_PW_RX, SFWL_PW_RD,
        SFWL_HUNT, SFWL_REC, SFWL_WR, SFWL_SUM_HI, SFWL_SUM_LO, SFWL_ERR_TX, SFWL_HALT
    } sfwl_state_t;

    // memory request towards the flash array
    typedef struct packed {
        logic        rd;     // read request, data next cycle
        logic        wr;     // program request, one cycle
        logic [15:0] addr;   // byte address
        logic [7:0]  wdata;  // program data
    } sfwl_mem_req_t;

    // byte from the receiver
    typedef struct packed {
        logic       valid;   // one-cycle pulse
        logic       err;     // framing or parity error
        logic [7:0] data;    // received byte
    } sfwl_rx_t;
endpackage

// *** design/sfwl_loader.sv ***
/*
 * serial flash write loader: the byte-level protocol of the write command.
 * assumes an external uart that delivers received bytes as one-cycle pulses,
 * accepts a byte when tx_ready is high, and uses baud_div as its divisor;
 * the uart performs the start-bit timing of the match byte itself and only
 * reports match_seen. flash answers reads one cycle after the request.
 * checksum arithmetic is the sum of all programmed bytes.
 */
`timescale 1ns/1ns
`include "sfwl_regs.svh"
module sfwl_loader
    import sfwl_pkg::*;
#(
    parameter int unsigned DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,          // freezes all state when low
    input  wire sfwl_rx_t         rx,          // received byte, same clock
    input  wire logic             match_seen,  // uart saw a rate-training byte
    input  wire logic             secure,      // security protection enabled
    input  wire logic [7:0]       rate_ok,     // rate code suits our clock
    input  wire logic [DIV_W-1:0] rate_div,    // divisor of that rate code
    input  wire logic             tx_ready,    // uart can take a byte
    output logic                  tx_valid,    // byte offered to uart
    output logic [7:0]            tx_data,     // byte to send
    output logic [DIV_W-1:0]      baud_div,    // current uart divisor
    output sfwl_mem_req_t         mem,         // flash request
    input  wire logic [7:0]       mem_rdata,   // flash read data
    output logic                  halted       // loader stopped until reset
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    sfwl_state_t      state, next_state;         // protocol step
    logic [7:0]       echo, next_echo;           // final error code of the burst
    logic [1:0]       rep, next_rep;             // error code repeat count
    logic [1:0]       phase, next_phase;         // error group A1/A3/final
    logic [1:0]       idx, next_idx;             // address byte / field index
    logic [15:0]      cnt_addr, next_cnt_addr;   // password count address
    logic [15:0]      cmp_addr, next_cmp_addr;   // password compare address
    logic [15:0]      ptr, next_ptr;             // memory walk pointer
    logic [7:0]       left, next_left;           // bytes left in field
    logic [7:0]       pw, next_pw;               // received password byte
    logic [7:0]       rtype, next_rtype;         // record type
    logic [7:0]       rsum, next_rsum;           // record checksum
    logic [15:0]      sum, next_sum;             // programmed-byte sum
    logic [DIV_W-1:0] div, next_div;             // uart divisor
    logic             rd_wait, next_rd_wait;     // flash read in flight
    logic [7:0]       txb, next_txb;             // registered tx data

    // byte classification shared by every step
    wire logic rx_ok  = rx.valid && !rx.err;
    wire logic rx_bad = rx.valid && rx.err;
    wire logic sent   = tx_valid && tx_ready;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // one combinational step covers every protocol state
    always_comb begin
        next_state = state; next_echo = echo; next_rep = rep; next_phase = phase;
        next_idx = idx; next_cnt_addr = cnt_addr; next_cmp_addr = cmp_addr;
        next_ptr = ptr; next_left = left; next_pw = pw; next_rtype = rtype;
        next_rsum = rsum; next_sum = sum; next_div = div; next_rd_wait = 1'b0;
        next_txb = txb;
        mem = '0;
        tx_valid = 1'b0;
        unique case (state)
            // idle after reset: only a clean 5AH wakes us
            SFWL_MATCH: begin
                // uart trained on a 5AH-shaped byte; only a clean 5AH counts
                if (rx_ok && rx.data == `SFWL_MATCH_BYTE) begin
                    next_div   = DIV_W'(`SFWL_DIV_INIT);
                    next_txb   = rx.data;
                    next_state = SFWL_ECHO_MATCH;
                end
            end
            // hold the echo until the uart takes it
            SFWL_ECHO_MATCH: begin
                tx_valid = 1'b1;
                if (sent) next_state = SFWL_RATE;
            end
            // rate code decides echo or error burst
            SFWL_RATE: begin
                if (rx_ok && rate_ok[0]) begin
                    next_txb = rx.data; next_state = SFWL_ECHO_RATE;
                end else if (rx.valid) begin
                    // wrong code for our clock, or a broken byte
                    next_echo = `SFWL_ERR_RATE; next_txb = `SFWL_ERR_A1;
                    next_rep = 2'h0; next_phase = 2'h0; next_state = SFWL_ERR_TX;
                end
            end
            // echo the code, then change divisor
            SFWL_ECHO_RATE: begin
                tx_valid = 1'b1;
                // switch only after the echo left at the old rate
                if (sent) begin
                    next_div = rate_div; next_state = SFWL_CMD;
                end
            end
            // only the write command is served here
            SFWL_CMD: begin
                if (rx_ok && rx.data == `SFWL_CMD_WRITE) begin
                    next_txb = rx.data; next_state = SFWL_ECHO_CMD;
                end else if (rx.valid) begin
                    next_echo = `SFWL_ERR_CMD; next_txb = `SFWL_ERR_A1;
                    next_rep = 2'h0; next_phase = 2'h0; next_state = SFWL_ERR_TX;
                end
            end
            // echo the command, then check protection
            SFWL_ECHO_CMD: begin
                tx_valid = 1'b1;
                if (sent) begin
                    next_idx = 2'h0;
                    // protected part refuses to write: halt at once
                    next_state = secure ? SFWL_HALT : SFWL_ADDR;
                end
            end
            // count and compare addresses, silent
            SFWL_ADDR: begin
                // four address bytes, high half first, no reply
                if (rx_bad) next_state = SFWL_HALT;
                else if (rx_ok) begin
                    unique case (idx)
                        2'h0: next_cnt_addr[15:8] = rx.data;
                        2'h1: next_cnt_addr[7:0]  = rx.data;
                        2'h2: next_cmp_addr[15:8] = rx.data;
                        2'h3: next_cmp_addr[7:0]  = rx.data;
                    endcase
                    next_idx = idx + 2'h1;
                    if (idx == 2'h3) begin
                        next_ptr = `SFWL_BLANK_FIRST; next_state = SFWL_BLANK;
                    end
                end
            end
            // blank check, two cycles per location;
            // bytes that arrive during the scan are dropped,
            // harmless while a line byte outlasts the scan
            SFWL_BLANK: begin
                // scan FFE0H..FFFFH; any programmed byte forces a password
                if (!rd_wait) begin
                    mem.rd = 1'b1; mem.addr = ptr; next_rd_wait = 1'b1;
                end else if (mem_rdata != `SFWL_ERASED) begin
                    mem.rd = 1'b1; mem.addr = cnt_addr; next_rd_wait = 1'b1;
                    next_state = SFWL_CNT_RD;
                end else if (ptr == `SFWL_BLANK_LAST) begin
                    next_state = SFWL_HUNT;
                end else next_ptr = ptr + 16'h1;
            end
            // password count arrives from flash
            SFWL_CNT_RD: begin
                if (rd_wait) begin
                    next_left = mem_rdata; next_ptr = cmp_addr;
                    // zero count is an address fault, treat as password error
                    next_state = (mem_rdata == 8'h00) ? SFWL_HALT : SFWL_PW_RX;
                end
            end
            // one password byte, then fetch its partner
            SFWL_PW_RX: begin
                if (rx_bad) next_state = SFWL_HALT;
                else if (rx_ok) begin
                    next_pw = rx.data; mem.rd = 1'b1; mem.addr = ptr;
                    next_rd_wait = 1'b1; next_state = SFWL_PW_RD;
                end
            end
            // compare against flash;
            // mismatch halts quietly, nothing is revealed
            SFWL_PW_RD: begin
                if (mem_rdata != pw) next_state = SFWL_HALT;
                else begin
                    next_ptr = ptr + 16'h1; next_left = left - 8'h1;
                    next_state = (left == 8'h1) ? SFWL_HUNT : SFWL_PW_RX;
                end
            end
            // record hunt: wait for the start mark;
            // garbage between records is normal, not an error
            SFWL_HUNT: begin
                // any clean byte but the start mark is dropped unanswered; a broken byte halts
                if (rx_bad) next_state = SFWL_HALT;
                else if (rx_ok && rx.data == `SFWL_START_MARK) begin
                    next_idx = 2'h0; next_state = SFWL_REC;
                end
            end
            // record header, summed for the record check;
            // an unknown type halts at once
            SFWL_REC: begin
                // header fields: length, addr hi, addr lo, type
                if (rx_bad) next_state = SFWL_HALT;
                else if (rx_ok) begin
                    next_rsum = (idx == 2'h0) ? rx.data : rsum + rx.data;
                    unique case (idx)
                        2'h0: next_left = rx.data;
                        2'h1: next_ptr[15:8] = rx.data;
                        2'h2: next_ptr[7:0] = rx.data;
                        2'h3: begin
                            next_rtype = rx.data;
                            if (rx.data != `SFWL_REC_DATA && rx.data != `SFWL_REC_END)
                                next_state = SFWL_HALT;
                            else next_state = SFWL_WR;
                        end
                    endcase
                    next_idx = idx + 2'h1;
                end
            end
            // program data, last byte closes the record;
            // a bad record sum halts silently
            SFWL_WR: begin
                // data bytes, then the record checksum byte
                if (rx_bad) next_state = SFWL_HALT;
                else if (rx_ok) begin
                    next_rsum = rsum + rx.data;
                    if (left != 8'h00) begin
                        mem.wr = 1'b1; mem.addr = ptr; mem.wdata = rx.data;
                        next_ptr = ptr + 16'h1; next_left = left - 8'h1;
                        next_sum = sum + {8'h00, rx.data};
                    end else if (rsum + rx.data != 8'h00) next_state = SFWL_HALT;
                    else if (rtype == `SFWL_REC_END) begin
                        next_txb = sum[15:8]; next_state = SFWL_SUM_HI;
                    end else next_state = SFWL_HUNT;
                end
            end
            // checksum high byte first
            SFWL_SUM_HI: begin
                tx_valid = 1'b1;
                if (sent) begin
                    next_txb = sum[7:0]; next_state = SFWL_SUM_LO;
                end
            end
            // low byte, then back to command wait
            SFWL_SUM_LO: begin
                tx_valid = 1'b1;
                if (sent) begin
                    next_sum = 16'h0000; next_state = SFWL_CMD;
                end
            end
            // error burst: three of each code;
            // txb loads one step ahead so tx_data never glitches
            SFWL_ERR_TX: begin
                tx_valid = 1'b1;
                if (sent) begin
                    next_rep = rep + 2'h1;
                    if (rep == `SFWL_ERR_REPEAT - 2'h1) begin
                        next_rep = 2'h0; next_phase = phase + 2'h1;
                        next_txb = (phase == 2'h0) ? `SFWL_ERR_A3 : echo;
                        if (phase == 2'h2) next_state = SFWL_HALT;
                    end
                end
            end
            SFWL_HALT: ;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // synchronous reset; ce low holds everything
    // one flop bank, so every state bit freezes together
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SFWL_MATCH; echo <= 8'h00; rep <= 2'h0; phase <= 2'h0;
            idx <= 2'h0; cnt_addr <= 16'h0000; cmp_addr <= 16'h0000;
            ptr <= 16'h0000; left <= 8'h00; pw <= 8'h00; rtype <= 8'h00;
            rsum <= 8'h00; sum <= 16'h0000; div <= DIV_W'(`SFWL_DIV_INIT);
            rd_wait <= 1'b0; txb <= 8'h00;
        end else if (ce) begin
            state <= next_state; echo <= next_echo; rep <= next_rep;
            phase <= next_phase; idx <= next_idx; cnt_addr <= next_cnt_addr;
            cmp_addr <= next_cmp_addr; ptr <= next_ptr; left <= next_left;
            pw <= next_pw; rtype <= next_rtype; rsum <= next_rsum;
            sum <= next_sum; div <= next_div; rd_wait <= next_rd_wait;
            txb <= next_txb;
        end
    end

    // match_seen only matters to the uart's own training; kept for visibility
    // data outputs straight from registers
    assign tx_data  = txb;
    assign baud_div = div;
    assign halted   = (state == SFWL_HALT);
    wire logic unused_ok = match_seen ^ (|rate_ok[7:1]);
endmodule

// *** tb/sfwl_flash_model.sv ***
/*
 * behavioural flash array facing the loader's memory request port.
 * assumes reads answer one cycle after mem.rd and the bench preloads arr.
 */
`timescale 1ns/1ns
module sfwl_flash_model
    import sfwl_pkg::*;
(
    input  wire logic          clk,
    input  wire sfwl_mem_req_t mem,
    output logic [7:0]         mem_rdata
);
    // ----------------------------------------------------------------
    // storage and read port
    // ----------------------------------------------------------------
    logic [7:0] arr [0:65535];  // byte array, bench writes it directly

    initial mem_rdata = 8'h00;

    // data only valid the cycle after a read; otherwise it toggles so
    // a loader sampling at the wrong time cannot get lucky
    always @(posedge clk) begin
        if (mem.wr) begin
            arr[mem.addr] <= mem.wdata;
        end
        mem_rdata <= mem.rd ? arr[mem.addr] : ~mem_rdata;
    end
endmodule

// *** tb/sfwl_loader_chk.sv ***
/*
 * concurrent checks on the loader's ports.
 * assumes one clock domain and is attached by the bind at the foot.
 */
`timescale 1ns/1ns
`include "sfwl_regs.svh"
module sfwl_loader_chk
    import sfwl_pkg::*;
#(
    parameter int unsigned DIV_W = 16
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             ce,
    input wire sfwl_rx_t         rx,
    input wire logic             match_seen,
    input wire logic             secure,
    input wire logic [7:0]       rate_ok,
    input wire logic [DIV_W-1:0] rate_div,
    input wire logic             tx_ready,
    input wire logic             tx_valid,
    input wire logic [7:0]       tx_data,
    input wire logic [DIV_W-1:0] baud_div,
    input wire sfwl_mem_req_t    mem,
    input wire logic [7:0]       mem_rdata,
    input wire logic             halted
);
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic       seen_tx;       // some byte offered since reset
    logic [2:0] cause_q;       // byte taken or sent in last edges
    logic       next_seen_tx;
    logic [2:0] next_cause_q;

    // window of three edges covers echo, error repeats and checksum
    always_comb begin
        next_seen_tx = seen_tx | tx_valid;
        next_cause_q = {cause_q[1:0], (rx.valid & ce) | (tx_valid & tx_ready)};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_tx <= 1'h0;
            cause_q <= 3'h0;
        end else begin
            seen_tx <= next_seen_tx;
            cause_q <= next_cause_q;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_match_echo_next: assert property (rx.valid && ce && !rx.err && rx.data == `SFWL_MATCH_BYTE
        && !seen_tx && !tx_valid |=> tx_valid && tx_data == `SFWL_MATCH_BYTE)
        else $error("match byte not echoed next cycle");
    a_nomatch_silent: assert property (rx.valid && ce && rx.data != `SFWL_MATCH_BYTE && !seen_tx
        |=> !tx_valid) else $error("reply to a non-match byte");
    a_baud_after_reset: assert property ($rose(rst_n) |-> baud_div == DIV_W'(`SFWL_DIV_INIT))
        else $error("divisor not at start rate");
    a_baud_on_echo: assert property (!$stable(baud_div) |-> $past(tx_valid && tx_ready)
        && baud_div == $past(rate_div)) else $error("divisor changed outside echo");
    a_tx_held: assert property (tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx_data))
        else $error("offered byte dropped or changed");
    a_tx_has_cause: assert property ($rose(tx_valid) |-> |cause_q)
        else $error("byte offered without cause");
    a_halt_sticky: assert property (halted |=> halted)
        else $error("left halt without reset");
    a_halt_silent: assert property (halted |-> !tx_valid && !mem.wr)
        else $error("activity while halted");
    a_wr_single: assert property (mem.wr |=> !mem.wr)
        else $error("program request longer than one cycle");

    c_halt: cover property ($rose(halted));
    c_rate: cover property (!$stable(baud_div));
    c_prog: cover property (mem.wr);
endmodule

bind sfwl_loader sfwl_loader_chk #(.DIV_W(DIV_W)) sfwl_loader_chk_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .rx(rx), .match_seen(match_seen), .secure(secure),
    .rate_ok(rate_ok), .rate_div(rate_div), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .baud_div(baud_div), .mem(mem), .mem_rdata(mem_rdata), .halted(halted)
);

// *** tb/serial_flash_write_loader_bench.sv ***
/*
 * self-checking bench of the write loader with a flash model behind it.
 * assumes the loader is the only uart client and the clock is 100 MHz.
 */
`timescale 1ns/1ns
`include "sfwl_regs.svh"
module serial_flash_write_loader_bench;
    import sfwl_pkg::*;
    typedef logic [7:0] sfwl_bytes_t[$];
    localparam int unsigned DIV_W = 16;
    logic clk, rst_n, ce, match_seen, secure, tx_ready, tx_valid, halted, talked;
    logic [7:0] rate_ok, tx_data, mem_rdata;
    logic [DIV_W-1:0] rate_div, baud_div;
    sfwl_rx_t rx;
    sfwl_mem_req_t mem;
    int n_fail, cmp_count;

    sfwl_loader #(.DIV_W(DIV_W)) sfwl_loader_i (.clk(clk), .rst_n(rst_n), .ce(ce), .rx(rx),
        .match_seen(match_seen), .secure(secure), .rate_ok(rate_ok), .rate_div(rate_div),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .baud_div(baud_div),
        .mem(mem), .mem_rdata(mem_rdata), .halted(halted));
    sfwl_flash_model sfwl_flash_model_i (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // any offered byte marks the current silent phase as broken
    always @(posedge clk) if (tx_valid === 1'h1) talked <= 1'h1;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one byte pulse, then idle gap; data line shows garbage when idle.
    // the gap outlasts the 64-cycle blank scan, which drops bytes
    task automatic send(input logic [7:0] b, input logic err);
        @(posedge clk);
        rx <= {1'h1, err, b};
        @(posedge clk);
        rx <= {1'h0, 1'h0, ~b};
        repeat (70) @(posedge clk);
    endtask

    task automatic send_all(input sfwl_bytes_t q);
        foreach (q[i]) send(q[i], 1'h0);
    endtask

    // waits for an offered byte, stalls, then accepts it at one edge
    task automatic expect_tx(input logic [7:0] e, input int stall);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_valid !== 1'h1 && n < 300);
        if (tx_valid !== 1'h1) begin
            n_fail++;
            $display("wrong value at %0t: no byte offered", $time);
            report_and_stop();
        end else begin
            repeat (stall) @(posedge clk);
            tx_ready <= 1'h1;
            @(posedge clk);
            chk(tx_data, e, "sent byte");
            tx_ready <= 1'h0;
        end
    endtask

    task automatic hush();
        @(posedge clk);
        talked = 1'h0;
    endtask

    task automatic expect_quiet(input int c);
        repeat (c) @(posedge clk);
        chk(talked, 1'h0, "byte during silence");
    endtask

    // erased array each run so no location is written twice
    task automatic fresh(input logic blank);
        for (int i = 0; i < 65536; i++) sfwl_flash_model_i.arr[i] = 8'hFF;
        if (!blank) begin
            sfwl_flash_model_i.arr[16'hFFE0] = 8'h00;
            sfwl_flash_model_i.arr[16'h2000] = 8'h02;
            sfwl_flash_model_i.arr[16'h2100] = 8'hAB;
            sfwl_flash_model_i.arr[16'h2101] = 8'hCD;
        end
        rst_n <= 1'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk(baud_div, DIV_W'(`SFWL_DIV_INIT), "start divisor");
        chk(halted, 1'h0, "halt after reset");
    endtask

    task automatic open_session();
        rate_ok <= 8'h01;
        rate_div <= 16'h0123;
        send(`SFWL_MATCH_BYTE, 1'h0);
        expect_tx(`SFWL_MATCH_BYTE, 0);
        send(`SFWL_RATE_DEFAULT, 1'h0);
        expect_tx(`SFWL_RATE_DEFAULT, 3);
        // divisor moves at the echo's own edge: look one edge later
        @(posedge clk);
        chk(baud_div, 16'h0123, "new divisor");
        send(`SFWL_CMD_WRITE, 1'h0);
        expect_tx(`SFWL_CMD_WRITE, 1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic s_blank_write();
        fresh(1'h1);
        hush();
        send(8'h11, 1'h0);
        expect_quiet(20);
        open_session();
        hush();
        // record avoids the top region alone
        send_all('{8'h20, 8'h00, 8'h21, 8'h00, 8'h55, 8'h3A, 8'h02, 8'h10, 8'h00, 8'h00,
                   8'h12, 8'h34, 8'hA8});
        chk(talked, 1'h0, "reply during records");
        send_all('{8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF});
        expect_tx(8'h00, 2);
        expect_tx(8'h46, 0);
        chk(sfwl_flash_model_i.arr[16'h1000], 8'h12, "programmed byte");
        chk(sfwl_flash_model_i.arr[16'h1001], 8'h34, "programmed byte");
        send(`SFWL_CMD_WRITE, 1'h0);
        expect_tx(`SFWL_CMD_WRITE, 0);
        chk(baud_div, 16'h0123, "kept divisor");
    endtask

    task automatic s_error(input logic bad_rate, input logic [7:0] code);
        fresh(1'h1);
        rate_ok <= {7'h00, !bad_rate};
        send(`SFWL_MATCH_BYTE, 1'h0);
        expect_tx(`SFWL_MATCH_BYTE, 0);
        send(bad_rate ? 8'h2A : `SFWL_RATE_DEFAULT, 1'h0);
        if (!bad_rate) begin
            expect_tx(`SFWL_RATE_DEFAULT, 0);
            send(8'h31, 1'h0);
        end
        for (int k = 0; k < 9; k++) begin
            expect_tx(k < 3 ? `SFWL_ERR_A1 : (k < 6 ? `SFWL_ERR_A3 : code), k % 2);
        end
        repeat (2) @(posedge clk);
        chk(halted, 1'h1, "halt after error codes");
        hush();
        send(`SFWL_MATCH_BYTE, 1'h0);
        expect_quiet(30);
    endtask

    task automatic s_password(input logic good);
        fresh(1'h0);
        open_session();
        hush();
        send_all('{8'h20, 8'h00, 8'h21, 8'h00, 8'hAB, good ? 8'hCD : 8'hCE});
        if (good) begin
            send_all('{8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF});
            expect_tx(8'h00, 0);
            expect_tx(8'h00, 0);
        end else begin
            expect_quiet(40);
            chk(halted, 1'h1, "halt on wrong password");
        end
    endtask

    // 0 address byte error, 1 record receive error, 2 protection, 3 bad record sum
    task automatic s_silent(input int kind);
        fresh(1'h1);
        secure <= (kind == 2);
        open_session();
        hush();
        if (kind == 0) begin
            send(8'h20, 1'h0);
            send(8'h00, 1'h1);
        end else if (kind != 2) begin
            send_all('{8'h20, 8'h00, 8'h21, 8'h00, 8'h3A, 8'h00, 8'h00, 8'h00, 8'h01});
            send(8'h00, kind == 1);
        end
        expect_quiet(40);
        chk(halted, 1'h1, "silent halt");
        secure <= 1'h0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        ce = 1'h1;
        match_seen = 1'h0;
        secure = 1'h0;
        tx_ready = 1'h0;
        talked = 1'h0;
        rate_ok = 8'h01;
        rate_div = 16'h0123;
        rx = {1'h0, 1'h0, 8'h00};
        n_fail = 0;
        cmp_count = 0;
        s_blank_write();
        s_error(1'h1, `SFWL_ERR_RATE);
        s_error(1'h0, `SFWL_ERR_CMD);
        s_password(1'h1);
        s_password(1'h0);
        for (int k = 0; k < 4; k++) s_silent(k);
        report_and_stop();
    end
endmodule
